// file: verilog/tegs_map.svh
// Register offsets, field positions, reset values and timing constants.
// Behaviour
// - Apply entry mask now, advance after duration.
// - Hold entry applies mask and requests preemption hold.
// - Release entry applies mask, releases after express frame.
// - Without preemption, hold and release act plainly.
// - Closed gates and hold persist until changed.
// - Stop finishes the cycle through last entry.
// - Guard band is largest frame times 8 over speed.
// - Oversize frames are never dropped by gates.
// - Opened queue gets a brief open window always.
// - Guard-all selects all or preemptible queues; lists without hold or release guard all.
// - Hold active: preemptible guard is fragment plus 64.
// - Preemptible means enabled and not opened by hold.
// - Future epoch activates exactly at epoch.
// - Past epoch activates at epoch plus whole cycles.
// - Buffered frames still leave after the gate closes.
// - Preemption needs port and queue enable, reset off.
// - Mask bit n controls queue n.
// - Durations counted in nanoseconds, states held throughout.
// - Initial gate states apply while idle or waiting for the epoch.
`ifndef TEGS_MAP_SVH
`define TEGS_MAP_SVH
`define TEGS_NS_PER_CLK 32'h0000000A
`define TEGS_BITS_PER_BYTE 32'h00000008
`define TEGS_HOLD_EXTRA 16'h0040
`define TEGS_MIN_OPEN_NS 32'h00000040
`define TEGS_QUEUES 8
`define TEGS_LIST_MAX 256
`define TEGS_A_CTRL 12'h000
`define TEGS_A_STATUS 12'h004
`define TEGS_A_CYCLE 12'h008
`define TEGS_A_BASE 12'h00C
`define TEGS_A_LEN 12'h010
`define TEGS_A_INIT 12'h014
`define TEGS_A_PREEMPT 12'h018
`define TEGS_A_SPEED 12'h01C
`define TEGS_A_FRAG 12'h020
`define TEGS_A_IDX 12'h024
`define TEGS_A_ENTRY 12'h028
`define TEGS_A_SDU 12'h040
`define TEGS_A_GUARD 12'h060
`define TEGS_A_BASE_LO 12'h030
`define TEGS_WIN_MASK 12'hFE0
`define TEGS_C_ENABLE 0
`define TEGS_C_CHANGE 1
`define TEGS_C_GUARDALL 2
`define TEGS_C_PORTPRE 3
`define TEGS_E_MASK_LO 0
`define TEGS_E_MASK_HI 7
`define TEGS_E_OP_LO 8
`define TEGS_E_OP_HI 9
`define TEGS_INIT_RST 8'hFF
`define TEGS_SPEED_RST 32'h000003E8
`endif

// file: verilog/tegs_pkg.sv
// Types shared by the egress gate scheduler.
package tegs_pkg;
    typedef enum logic [1:0] {
        TEGS_OP_SET = 2'h0,
        TEGS_OP_HOLD = 2'h1,
        TEGS_OP_RELEASE = 2'h2
    } tegs_op_t;
    typedef enum logic [1:0] {
        TEGS_IDLE = 2'h0,
        TEGS_WAIT = 2'h1,
        TEGS_RUN = 2'h3,
        TEGS_STOP = 2'h2
    } tegs_state_t;
endpackage

// file: verilog/tegs_guard_calc.sv
// Guard band calculator for one queue.
`timescale 1ns/1ns
`default_nettype none
`include "tegs_map.svh"
module tegs_guard_calc (
    // Inputs.
    input wire logic [15:0] maxSdu,
    input wire logic [15:0] fragSize,
    input wire logic [31:0] speedMbps,
    input wire logic useHoldGuard,
    // Result in nanoseconds.
    output logic [31:0] guardNs
);
    logic [47:0] bits;
    logic [15:0] sizeB;
    // Picks the size and divides its bit count by speed in Mb/s.
    always_comb begin
        sizeB = useHoldGuard ? 16'(fragSize + `TEGS_HOLD_EXTRA) : maxSdu;
        bits = 48'(sizeB) * 48'(`TEGS_BITS_PER_BYTE) * 48'h3E8;
        guardNs = (speedMbps == 32'h0) ? 32'h0 : 32'(bits / 48'(speedMbps));
    end
endmodule
`default_nettype wire

// file: verilog/tegs_scheduler.sv
// Egress gate scheduler with an APB register slave.
`timescale 1ns/1ns
`default_nettype none
`include "tegs_map.svh"
module tegs_scheduler (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Global time in nanoseconds, same clock domain.
    input wire logic [63:0] timeNs,
    // MAC interface.
    input wire logic expressBusy,
    output logic [7:0] gateOpen,
    output logic [7:0] gateGuarded,
    output logic preemptHold,
    output logic [7:0] queuePreemptible
);
    // Gate list memory.
    logic [9:0] listMem [0:`TEGS_LIST_MAX-1];
    logic [31:0] durMem [0:`TEGS_LIST_MAX-1];
    logic [15:0] sduMem [0:`TEGS_QUEUES-1];
    // Configuration registers.
    logic [3:0] ctrl_ff, nxt_ctrl;
    logic [31:0] cycle_ff, nxt_cycle;
    logic [63:0] base_ff, nxt_base;
    logic [8:0] len_ff, nxt_len;
    logic [7:0] init_ff, nxt_init;
    logic [7:0] qPre_ff, nxt_qPre;
    logic [31:0] speed_ff, nxt_speed;
    logic [15:0] frag_ff, nxt_frag;
    logic [7:0] idx_ff, nxt_idx;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;
    // Schedule state.
    tegs_pkg::tegs_state_t st_ff, nxt_st;
    logic [7:0] ent_ff, nxt_ent;
    logic [31:0] entNs_ff, nxt_entNs;
    logic [31:0] cycNs_ff, nxt_cycNs;
    logic [63:0] start_ff, nxt_start;
    logic [7:0] gate_ff, nxt_gate;
    logic hold_ff, nxt_hold;
    logic relPend_ff, nxt_relPend;
    logic [7:0] holdOpen_ff, nxt_holdOpen;
    logic listPre_ff, nxt_listPre;
    logic stopReq_ff, nxt_stopReq;
    logic access, wr, rd, wrSetup;
    logic [31:0] guardNs [0:`TEGS_QUEUES-1];
    logic [7:0] preQ;
    logic [9:0] curEnt;
    logic [31:0] curDur;
    logic lastEnt;

    // Preemption is active only with both enables set.
    function automatic logic [7:0] preOn(input logic port, input logic [7:0] q);
        preOn = port ? q : 8'h00;
    endfunction

    // True when an address falls inside an eight-word window.
    function automatic logic inWin(input logic [11:0] a,
                                   input logic [11:0] b);
        inWin = ((a & `TEGS_WIN_MASK) == b);
    endfunction

    // Addresses that accept a write; any other write answers an error.
    function automatic logic wrMap(input logic [11:0] a);
        unique case (a)
            `TEGS_A_CTRL, `TEGS_A_CYCLE, `TEGS_A_BASE, `TEGS_A_BASE_LO,
            `TEGS_A_LEN, `TEGS_A_INIT, `TEGS_A_PREEMPT, `TEGS_A_SPEED,
            `TEGS_A_FRAG, `TEGS_A_IDX, `TEGS_A_ENTRY,
            `TEGS_A_ENTRY + 12'h004: wrMap = 1'b1;
            default: wrMap = inWin(a, `TEGS_A_SDU);
        endcase
    endfunction

    // Read data and error are decoded in the setup cycle, so that they
    // stand in flip-flops through the zero-wait access phase.
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign wrSetup = psel && !penable && pwrite;
    assign pready = 1'b1;
    assign prdata = rdata_ff;
    assign pslverr = err_ff;
    assign curEnt = listMem[ent_ff];
    assign curDur = durMem[ent_ff];
    assign lastEnt = (9'(ent_ff) + 9'h1 >= len_ff);

    // An enabled queue is preemptible unless a hold entry of the list opens it.
    assign preQ = preOn(ctrl_ff[`TEGS_C_PORTPRE], qPre_ff) & ~holdOpen_ff;
    assign queuePreemptible = preQ;

    // One guard calculator per queue.
    genvar g;
    generate
        for (g = 0; g < `TEGS_QUEUES; g = g + 1) begin : guardGen
            tegs_guard_calc uCalc (
                .maxSdu(sduMem[g]),
                .fragSize(frag_ff),
                .speedMbps(speed_ff),
                .useHoldGuard(hold_ff && preQ[g]),
                .guardNs(guardNs[g])
            );
        end
    endgenerate

    // Guard band flags: a gate that is open but whose guard window has
    // started stops new frames; the open entry always keeps a minimum
    // window so an opened queue is never starved.
    always_comb begin
        logic [31:0] left;
        logic [31:0] gb;
        left = 32'h0;
        gb = 32'h0;
        for (int q = 0; q < `TEGS_QUEUES; q++) begin
            left = (curDur > entNs_ff) ? curDur - entNs_ff : 32'h0;
            gb = guardNs[q];
            if (gb + `TEGS_MIN_OPEN_NS > curDur) begin
                gb = (curDur > `TEGS_MIN_OPEN_NS) ?
                    curDur - `TEGS_MIN_OPEN_NS : 32'h0;
            end
            gateGuarded[q] = (st_ff == tegs_pkg::TEGS_RUN) && gate_ff[q] &&
                (left <= gb) &&
                (!listPre_ff || ctrl_ff[`TEGS_C_GUARDALL] || preQ[q]);
        end
    end
    // Oversize frames pass; the gate only opens or closes a queue.
    assign gateOpen = gate_ff;
    assign preemptHold = hold_ff;

    // APB register writes and read data.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cycle = cycle_ff;
        nxt_base = base_ff;
        nxt_len = len_ff;
        nxt_init = init_ff;
        nxt_qPre = qPre_ff;
        nxt_speed = speed_ff;
        nxt_frag = frag_ff;
        nxt_idx = idx_ff;
        nxt_rdata = 32'h0;
        nxt_err = 1'b0;
        nxt_ctrl[`TEGS_C_CHANGE] = 1'b0;
        if (wr) begin
            unique case (paddr)
                `TEGS_A_CTRL: nxt_ctrl = pwdata[3:0];
                `TEGS_A_CYCLE: nxt_cycle = pwdata;
                `TEGS_A_BASE: nxt_base[63:32] = pwdata;
                `TEGS_A_BASE_LO: nxt_base[31:0] = pwdata;
                `TEGS_A_LEN: nxt_len = pwdata[8:0];
                `TEGS_A_INIT: nxt_init = pwdata[7:0];
                `TEGS_A_PREEMPT: nxt_qPre = pwdata[7:0];
                `TEGS_A_SPEED: nxt_speed = pwdata;
                `TEGS_A_FRAG: nxt_frag = pwdata[15:0];
                `TEGS_A_IDX: nxt_idx = pwdata[7:0];
                default: begin
                end
            endcase
        end
        if (wrSetup) begin
            nxt_err = !wrMap(paddr);
        end else if (rd) begin
            unique case (paddr)
                `TEGS_A_CTRL: nxt_rdata = {28'h0, ctrl_ff};
                `TEGS_A_STATUS: nxt_rdata = {14'h0, relPend_ff, hold_ff,
                    ent_ff, gate_ff};
                `TEGS_A_CYCLE: nxt_rdata = cycle_ff;
                `TEGS_A_BASE: nxt_rdata = base_ff[63:32];
                `TEGS_A_BASE_LO: nxt_rdata = base_ff[31:0];
                `TEGS_A_LEN: nxt_rdata = {23'h0, len_ff};
                `TEGS_A_INIT: nxt_rdata = {24'h0, init_ff};
                `TEGS_A_PREEMPT: nxt_rdata = {24'h0, qPre_ff};
                `TEGS_A_SPEED: nxt_rdata = speed_ff;
                `TEGS_A_FRAG: nxt_rdata = {16'h0, frag_ff};
                `TEGS_A_IDX: nxt_rdata = {24'h0, idx_ff};
                `TEGS_A_ENTRY: nxt_rdata = {22'h0, listMem[idx_ff]};
                `TEGS_A_ENTRY + 12'h004: nxt_rdata = durMem[idx_ff];
                default: begin
                    if (inWin(paddr, `TEGS_A_SDU)) begin
                        nxt_rdata = {16'h0, sduMem[paddr[4:2]]};
                    end else if (inWin(paddr, `TEGS_A_GUARD)) begin
                        nxt_rdata = guardNs[paddr[4:2]];
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            endcase
        end
    end

    // Configuration and read response registers.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_ff <= 4'h0;
            cycle_ff <= 32'h0;
            base_ff <= 64'h0;
            len_ff <= 9'h0;
            init_ff <= `TEGS_INIT_RST;
            qPre_ff <= 8'h00;
            speed_ff <= `TEGS_SPEED_RST;
            frag_ff <= 16'h0;
            idx_ff <= 8'h0;
            rdata_ff <= 32'h0;
            err_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cycle_ff <= nxt_cycle;
            base_ff <= nxt_base;
            len_ff <= nxt_len;
            init_ff <= nxt_init;
            qPre_ff <= nxt_qPre;
            speed_ff <= nxt_speed;
            frag_ff <= nxt_frag;
            idx_ff <= nxt_idx;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    // List and frame size memories have no reset.
    always_ff @(posedge core_clk) begin
        if (wr && paddr == `TEGS_A_ENTRY) begin
            listMem[idx_ff] <= pwdata[9:0];
        end
        if (wr && paddr == `TEGS_A_ENTRY + 12'h004) begin
            durMem[idx_ff] <= pwdata;
        end
        if (wr && inWin(paddr, `TEGS_A_SDU)) begin
            sduMem[paddr[4:2]] <= pwdata[15:0];
        end
    end

    // Schedule walk: waits for the epoch, then steps entries in 10 ns clock ticks.
    always_comb begin
        logic [63:0] late;
        logic [63:0] cyc64;
        logic [7:0] hOpen;
        logic anyPre;
        late = 64'h0;
        cyc64 = {32'h0, cycle_ff};
        hOpen = 8'h00;
        anyPre = 1'b0;
        nxt_st = st_ff;
        nxt_ent = ent_ff;
        nxt_entNs = entNs_ff;
        nxt_cycNs = cycNs_ff;
        nxt_start = start_ff;
        nxt_gate = gate_ff;
        nxt_hold = hold_ff;
        nxt_relPend = relPend_ff;
        nxt_holdOpen = holdOpen_ff;
        nxt_listPre = listPre_ff;
        nxt_stopReq = stopReq_ff || (st_ff == tegs_pkg::TEGS_RUN &&
            !ctrl_ff[`TEGS_C_ENABLE]);
        for (int i = 0; i < `TEGS_LIST_MAX; i++) begin
            if (9'(i) < len_ff) begin
                if (listMem[i][`TEGS_E_OP_HI:`TEGS_E_OP_LO] != 2'h0) begin
                    anyPre = 1'b1;
                end
                if (listMem[i][`TEGS_E_OP_HI:`TEGS_E_OP_LO] == 2'h1) begin
                    hOpen = hOpen | listMem[i][`TEGS_E_MASK_HI:`TEGS_E_MASK_LO];
                end
            end
        end
        // A release waits for the express frame in flight to end.
        if (relPend_ff && !expressBusy) begin
            nxt_hold = 1'b0;
            nxt_relPend = 1'b0;
        end
        unique case (st_ff)
            tegs_pkg::TEGS_IDLE: begin
                nxt_gate = init_ff;
                if (ctrl_ff[`TEGS_C_CHANGE] && ctrl_ff[`TEGS_C_ENABLE]) begin
                    nxt_st = tegs_pkg::TEGS_WAIT;
                    nxt_holdOpen = hOpen;
                    nxt_listPre = anyPre;
                    nxt_stopReq = 1'b0;
                    if (base_ff >= timeNs || cyc64 == 64'h0) begin
                        nxt_start = base_ff;
                    end else begin
                        late = timeNs - base_ff;
                        nxt_start = base_ff + (late / cyc64 + 64'h1) * cyc64;
                    end
                end
            end
            tegs_pkg::TEGS_WAIT: begin
                if (timeNs >= start_ff) begin
                    nxt_st = tegs_pkg::TEGS_RUN;
                    nxt_ent = 8'h0;
                    nxt_entNs = 32'h0;
                    nxt_cycNs = 32'h0;
                end
            end
            tegs_pkg::TEGS_RUN: begin
                // Entry start: apply mask and the preemption action.
                if (entNs_ff == 32'h0 && cycNs_ff < cycle_ff) begin
                    nxt_gate = curEnt[`TEGS_E_MASK_HI:`TEGS_E_MASK_LO];
                    if (ctrl_ff[`TEGS_C_PORTPRE] && qPre_ff != 8'h00) begin
                        if (curEnt[`TEGS_E_OP_HI:`TEGS_E_OP_LO] == 2'h1) begin
                            nxt_hold = 1'b1;
                            nxt_relPend = 1'b0;
                        end else if (curEnt[`TEGS_E_OP_HI:`TEGS_E_OP_LO] == 2'h2) begin
                            nxt_relPend = 1'b1;
                            nxt_hold = hold_ff && expressBusy ? 1'b1 : 1'b0;
                            nxt_relPend = hold_ff && expressBusy;
                        end
                    end
                end
                nxt_entNs = 32'(entNs_ff + `TEGS_NS_PER_CLK);
                nxt_cycNs = 32'(cycNs_ff + `TEGS_NS_PER_CLK);
                if (nxt_cycNs >= cycle_ff) begin
                    // Period over: restart the list or stop after it.
                    nxt_ent = 8'h0;
                    nxt_entNs = 32'h0;
                    nxt_cycNs = 32'h0;
                    if (nxt_stopReq) begin
                        nxt_st = tegs_pkg::TEGS_STOP;
                    end
                end else if (nxt_entNs >= curDur) begin
                    if (!lastEnt) begin
                        nxt_ent = 8'(ent_ff + 8'h1);
                        nxt_entNs = 32'h0;
                    end else begin
                        nxt_entNs = curDur;
                    end
                end
            end
            tegs_pkg::TEGS_STOP: begin
                // Gates and hold stay as the last entry left them.
                if (ctrl_ff[`TEGS_C_CHANGE] && ctrl_ff[`TEGS_C_ENABLE]) begin
                    nxt_st = tegs_pkg::TEGS_IDLE;
                end
            end
        endcase
    end

    // Schedule registers.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff <= tegs_pkg::TEGS_IDLE;
            ent_ff <= 8'h0;
            entNs_ff <= 32'h0;
            cycNs_ff <= 32'h0;
            start_ff <= 64'h0;
            gate_ff <= `TEGS_INIT_RST;
            hold_ff <= 1'b0;
            relPend_ff <= 1'b0;
            holdOpen_ff <= 8'h00;
            listPre_ff <= 1'b0;
            stopReq_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ent_ff <= nxt_ent;
            entNs_ff <= nxt_entNs;
            cycNs_ff <= nxt_cycNs;
            start_ff <= nxt_start;
            gate_ff <= nxt_gate;
            hold_ff <= nxt_hold;
            relPend_ff <= nxt_relPend;
            holdOpen_ff <= nxt_holdOpen;
            listPre_ff <= nxt_listPre;
            stopReq_ff <= nxt_stopReq;
        end
    end

    // Checks on the schedule behaviour.
    sequence sqEpoch;
        st_ff == tegs_pkg::TEGS_WAIT && timeNs >= start_ff;
    endsequence
    AST_EPOCH_RUN: assert property (@(posedge core_clk) disable iff (!rst_n)
        sqEpoch |=> st_ff == tegs_pkg::TEGS_RUN)
        else $error("Schedule did not start at epoch.");
    AST_MASK_APPLY: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff == tegs_pkg::TEGS_RUN && entNs_ff == 32'h0 &&
        cycNs_ff < cycle_ff |=> gate_ff == $past(curEnt[7:0]))
        else $error("Entry mask not applied.");
    AST_HOLD_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff == tegs_pkg::TEGS_RUN && entNs_ff == 32'h0 &&
        cycNs_ff < cycle_ff && curEnt[9:8] == 2'h1 &&
        ctrl_ff[3] && qPre_ff != 8'h00 |=> hold_ff)
        else $error("Hold not asserted.");
    AST_REL_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        relPend_ff && expressBusy |=> hold_ff)
        else $error("Release during express frame.");
    AST_NOPRE_NOHOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl_ff[3] && !hold_ff |=> !hold_ff)
        else $error("Hold without preemption.");
    AST_STOP_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff == tegs_pkg::TEGS_STOP && $past(st_ff) == tegs_pkg::TEGS_STOP
        |-> $stable(gate_ff))
        else $error("Gates changed after stop.");
    AST_PRE_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl_ff[3] |-> queuePreemptible == 8'h00)
        else $error("Preemptible without port enable.");
    AST_IDLE_INIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff == tegs_pkg::TEGS_IDLE ##1 st_ff == tegs_pkg::TEGS_IDLE
        |-> gate_ff == $past(init_ff))
        else $error("Initial gate state not used.");
endmodule
`default_nettype wire

// file: verification/tegs_mac_model.sv
// Egress MAC model that sends express frames through open gates.
`timescale 1ns/1ns
`default_nettype none
module tegs_mac_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Gate side of the scheduler.
    input wire logic [7:0] gateOpen,
    input wire logic [7:0] gateGuarded,
    input wire logic [7:0] queuePreemptible,
    // Frame activity.
    output logic expressBusy
);
    integer seed = 32'h00002E27;
    int left;
    // Starts express frames of one to eight cycles on unguarded gates.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            expressBusy <= 1'b0;
            left = 0;
        end else if (left > 0) begin
            left = left - 1;
            expressBusy <= (left != 0);
        end else if (|(gateOpen & ~gateGuarded & ~queuePreemptible)
                     && ($unsigned($random(seed)) % 3 == 0)) begin
            left = 1 + ($unsigned($random(seed)) % 8);
            expressBusy <= 1'b1;
        end else begin
            expressBusy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: verification/tegs_scheduler_tb.sv
// Self-checking bench for the egress gate scheduler.
`timescale 1ns/1ns
`default_nettype none
`include "tegs_map.svh"
module tegs_scheduler_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [63:0] timeNs = 64'h0000000000000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic expressBusy;
    logic [7:0] gateOpen;
    logic [7:0] gateGuarded;
    logic preemptHold;
    logic [7:0] queuePreemptible;
    logic [31:0] rd;
    logic err;
    logic [31:0] sdu;
    logic [31:0] spd;
    logic [63:0] t0;
    logic [63:0] t1;
    integer seed = 32'h00002E27;
    int miscompares = 0;
    int checks = 0;

    tegs_scheduler tegs_scheduler_i (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timeNs(timeNs), .expressBusy(expressBusy),
        .gateOpen(gateOpen), .gateGuarded(gateGuarded),
        .preemptHold(preemptHold), .queuePreemptible(queuePreemptible));
    tegs_mac_model tegs_mac_model_i (.core_clk(core_clk), .rst_n(rst_n),
        .gateOpen(gateOpen), .gateGuarded(gateGuarded),
        .queuePreemptible(queuePreemptible), .expressBusy(expressBusy));

    // Clock and a global time base that steps 10 ns per cycle.
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        timeNs <= timeNs + 64'h000000000000000A;
    end

    task automatic end_sim();
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic fail_out();
        miscompares++;
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Guard band in ns: bytes times 8 bits over Mb/s, scaled to ns.
    function automatic logic [31:0] guard_exp(input logic [31:0] s,
                                              input logic [31:0] v);
        return (s * `TEGS_BITS_PER_BYTE * 32'h000003E8) / v;
    endfunction

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) begin
            fail_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask

    // Waits a bounded time for a gate pattern and notes the time seen.
    task automatic wait_gate(input logic [7:0] m, output logic [63:0] t);
        int n;
        n = 0;
        while (gateOpen !== m && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 2000) begin
            fail_out();
        end
        t = timeNs;
    endtask

    task automatic put_entry(input logic [31:0] i, input tegs_pkg::tegs_op_t op,
                             input logic [7:0] m, input logic [31:0] dur);
        apb(1'b1, `TEGS_A_IDX, i);
        apb(1'b1, `TEGS_A_ENTRY, {22'h000000, op, m});
        apb(1'b1, `TEGS_A_ENTRY + 12'h004, dur);
    endtask

    // Runs a three-entry list in a 300 ns cycle, then stops it.
    task automatic run_sched(input logic [31:0] ctrl, input logic [31:0] hold,
                             input logic [31:0] pre);
        do_reset();
        // Preempting runs start at a future epoch, plain runs at a past one.
        t1 = ctrl[3] ? timeNs + 64'h00000000000007D0 : 64'h0000000000000000;
        apb(1'b1, `TEGS_A_CYCLE, 32'h0000012C);
        apb(1'b1, `TEGS_A_PREEMPT, 32'h000000E0);
        apb(1'b1, `TEGS_A_BASE, 32'h00000000);
        apb(1'b1, `TEGS_A_BASE_LO, t1[31:0]);
        apb(1'b1, `TEGS_A_LEN, 32'h00000003);
        put_entry(32'h0, tegs_pkg::TEGS_OP_HOLD, 8'h80, 32'h64);
        put_entry(32'h1, tegs_pkg::TEGS_OP_RELEASE, 8'h60, 32'h64);
        put_entry(32'h2, tegs_pkg::TEGS_OP_SET, 8'h1F, 32'h32);
        apb(1'b1, `TEGS_A_CTRL, ctrl | 32'h00000003);
        wait_gate(8'h80, t0);
        if (ctrl[3]) begin
            chk(32'(t0 - t1), 32'h00000014);
        end else begin
            chk({31'h0, (t0 % 64'h12C) == 64'h014}, 32'h1);
        end
        repeat (2) @(posedge core_clk);
        chk({31'h0, preemptHold}, hold);
        chk({24'h0, queuePreemptible}, pre);
        chk({24'h0, gateGuarded}, 32'h0);
        apb(1'b0, `TEGS_A_GUARD + 12'h014, 32'h0);
        if (hold[0]) begin
            chk(rd, guard_exp(32'h40, `TEGS_SPEED_RST));
        end
        // Queue 7 is now inside its clamped guard window.
        @(posedge core_clk);
        chk({24'h0, gateGuarded}, {24'h0, ctrl[2], 7'h0});
        wait_gate(8'h60, t1);
        chk(32'(t1 - t0), 32'h64);
        wait_gate(8'h1F, t0);
        chk(32'(t0 - t1), 32'h64);
        chk({31'h0, preemptHold}, 32'h0);
        wait_gate(8'h80, t1);
        chk(32'(t1 - t0), 32'h64);
        apb(1'b1, `TEGS_A_CTRL, ctrl);
        wait_gate(8'h1F, t0);
        repeat (25) @(posedge core_clk);
        chk({24'h0, gateOpen}, 32'h1F);
    endtask

    // Bounds the whole run.
    initial begin
        repeat (100000) @(posedge core_clk);
        fail_out();
    end

    // Reset values, refusal, guard bands, then plain and preempting runs.
    initial begin
        do_reset();
        chk({24'h0, gateOpen}, 32'hFF);
        chk({31'h0, preemptHold}, 32'h0);
        chk({24'h0, queuePreemptible}, 32'h0);
        apb(1'b0, `TEGS_A_INIT, 32'h0);
        chk(rd, `TEGS_INIT_RST);
        apb(1'b0, `TEGS_A_SPEED, 32'h0);
        chk(rd, `TEGS_SPEED_RST);
        apb(1'b1, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            sdu = $random(seed) & 32'h000003FF;
            spd = (i % 2 == 1) ? 32'h00000064 : 32'h000003E8;
            apb(1'b1, `TEGS_A_SPEED, spd);
            apb(1'b1, `TEGS_A_SDU + 12'(i * 4), sdu);
            apb(1'b0, `TEGS_A_GUARD + 12'(i * 4), 32'h0);
            chk(rd, guard_exp(sdu, spd));
        end
        apb(1'b1, `TEGS_A_SDU + 12'h01C, 32'h000003FF);
        run_sched(32'h00000000, 32'h0, 32'h00);
        run_sched(32'h0000000C, 32'h1, 32'h60);
        end_sim();
    end
endmodule
`default_nettype wire
